// >>> hw/bsl_pkg.sv
// Purpose: Shared constants for the bit sync loop configuration block
// Assumes: 50 MHz system clock, 8-bit configuration register
// Notes:   Rate offsets are in units of 2^-15 of the nominal data rate
package bsl_pkg;
	localparam logic [5:0] BSL_CFG_ADDR     = 6'h19;
	localparam logic [7:0] BSL_CFG_RESET    = 8'h6C;
	localparam int         BSL_PRE_KI_MSB   = 7;
	localparam int         BSL_PRE_KI_LSB   = 6;
	localparam int         BSL_PRE_KP_MSB   = 5;
	localparam int         BSL_PRE_KP_LSB   = 4;
	localparam int         BSL_POST_KI_BIT  = 3;
	localparam int         BSL_POST_KP_BIT  = 2;
	localparam int         BSL_CLAMP_MSB    = 1;
	localparam int         BSL_CLAMP_LSB    = 0;
	localparam logic [1:0] BSL_CLAMP_OFF    = 2'h0;
	localparam logic [1:0] BSL_CLAMP_LOW    = 2'h1;
	localparam logic [1:0] BSL_CLAMP_MID    = 2'h2;
	// Gains are counted in halves of the base gain
	localparam logic [3:0] BSL_HALF_GAIN    = 4'h1;
	localparam logic [3:0] BSL_UNIT_GAIN    = 4'h2;
	// Base gains as right shifts of the scaled error
	localparam int         BSL_KI_SHIFT     = 3;
	localparam int         BSL_KP_SHIFT     = 1;
	localparam int         BSL_ERR_W        = 8;
	localparam int         BSL_PROD_W       = 13;
	localparam int         BSL_ACC_W        = 16;
	localparam int         BSL_FRAC_BITS    = 15;
	// Clamp limits in thousandths of a percent
	localparam int         BSL_LIM_LOW_MP   = 3125;
	localparam int         BSL_LIM_MID_MP   = 6250;
	localparam int         BSL_LIM_HIGH_MP  = 12500;
	localparam int         BSL_MP_FULL      = 100000;
	localparam logic signed [BSL_ACC_W-1:0] BSL_LIM_LOW =
		BSL_ACC_W'((2**BSL_FRAC_BITS) * BSL_LIM_LOW_MP / BSL_MP_FULL);
	localparam logic signed [BSL_ACC_W-1:0] BSL_LIM_MID =
		BSL_ACC_W'((2**BSL_FRAC_BITS) * BSL_LIM_MID_MP / BSL_MP_FULL);
	localparam logic signed [BSL_ACC_W-1:0] BSL_LIM_HIGH =
		BSL_ACC_W'((2**BSL_FRAC_BITS) * BSL_LIM_HIGH_MP / BSL_MP_FULL);
	// Error that always yields a nonzero integral step
	localparam logic signed [BSL_ERR_W-1:0] BSL_ERR_MIN_STEP =
		BSL_ERR_W'(2**(BSL_KI_SHIFT + 1));
	typedef enum logic {BSL_PRESYNC, BSL_POSTSYNC} bsl_phase_t;
endpackage

// >>> hw/bsl_gain_scale.sv
// Purpose: Multiply a timing error by a gain counted in half steps
// Assumes: Gain code is unsigned, at most eight halves
// Notes:   Pure combinational; the caller registers the result
module bsl_gain_scale
	import bsl_pkg::*;
(
	input  wire logic signed [BSL_ERR_W-1:0]  err,
	input  wire logic        [3:0]            halves,
	output logic      signed [BSL_PROD_W-1:0] prod
);
	assign prod = $signed(err) * $signed({1'b0, halves});
endmodule

// >>> hw/bsl_clk_loop_cfg.sv
// Purpose: Clock recovery loop gain selection and rate offset clamp
// Assumes: Register port and loop inputs synchronous to sys_clk
// Notes:   Register read data appear one cycle after the address
module bsl_clk_loop_cfg
	import bsl_pkg::*;
(
	input  wire logic                        sys_clk,
	input  wire logic                        rst_n,
	input  wire logic [5:0]                  reg_addr,
	input  wire logic                        reg_wr_en,
	input  wire logic [7:0]                  reg_wr_data,
	output logic      [7:0]                  reg_rd_data,
	input  wire logic                        loop_freeze_until_carrier,
	input  wire logic                        carrier_sense,
	input  wire logic                        sync_detect,
	input  wire logic                        rx_restart,
	input  wire logic                        err_valid,
	input  wire logic signed [BSL_ERR_W-1:0] err_in,
	output logic                             adj_valid,
	output logic signed [BSL_ACC_W-1:0]      phase_adj,
	output logic signed [BSL_ACC_W-1:0]      rate_offset,
	output logic [3:0]                       ki_sel,
	output logic [3:0]                       kp_sel,
	output logic                             post_sync,
	output logic                             loop_frozen
);
	logic [7:0]                     cfg_reg;
	logic [7:0]                     rd_data_reg;
	bsl_phase_t                     phase_reg;
	logic                           post_active;
	logic                           frozen_now;
	logic                           upd;
	logic [3:0]                     pre_ki;
	logic [3:0]                     pre_kp;
	logic [3:0]                     ki_cur;
	logic [3:0]                     kp_cur;
	logic signed [BSL_PROD_W-1:0]   ki_prod;
	logic signed [BSL_PROD_W-1:0]   kp_prod;
	logic signed [BSL_ACC_W-1:0]    int_step;
	logic signed [BSL_ACC_W-1:0]    p_step;
	logic signed [BSL_ACC_W-1:0]    lim;
	logic signed [BSL_ACC_W:0]      acc_sum;
	logic signed [BSL_ACC_W-1:0]    acc_next;
	logic signed [BSL_ACC_W-1:0]    acc_reg;
	logic signed [BSL_ACC_W-1:0]    phase_reg_q;
	logic                           adj_valid_reg;
	logic [3:0]                     ki_sel_reg;
	logic [3:0]                     kp_sel_reg;
	logic                           frozen_reg;
	logic [1:0]                     clamp_code;

	assign clamp_code = cfg_reg[BSL_CLAMP_MSB:BSL_CLAMP_LSB];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= BSL_CFG_RESET;
		end else if (reg_wr_en && reg_addr == BSL_CFG_ADDR) begin
			cfg_reg <= reg_wr_data;
		end
	end

	// Unmapped addresses read zero so software sees a hole, not an alias
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_reg <= 8'h00;
		end else begin
			rd_data_reg <= (reg_addr == BSL_CFG_ADDR) ? cfg_reg : 8'h00;
		end
	end

	// Sync detect beats a restart in the same cycle so no lock is lost
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= BSL_PRESYNC;
		end else if (sync_detect) begin
			phase_reg <= BSL_POSTSYNC;
		end else if (rx_restart) begin
			phase_reg <= BSL_PRESYNC;
		end
	end

	// The pulse itself selects post-sync gains without waiting a cycle
	assign post_active = sync_detect || (phase_reg == BSL_POSTSYNC);

	always_comb begin
		pre_ki = {1'b0, cfg_reg[BSL_PRE_KI_MSB:BSL_PRE_KI_LSB], 1'b0}
			+ BSL_UNIT_GAIN;
		pre_kp = {1'b0, cfg_reg[BSL_PRE_KP_MSB:BSL_PRE_KP_LSB], 1'b0}
			+ BSL_UNIT_GAIN;
		ki_cur = pre_ki;
		kp_cur = pre_kp;
		if (post_active) begin
			if (cfg_reg[BSL_POST_KI_BIT]) begin
				ki_cur = BSL_HALF_GAIN;
			end
			if (cfg_reg[BSL_POST_KP_BIT]) begin
				kp_cur = BSL_UNIT_GAIN;
			end
		end
	end

	bsl_gain_scale u_ki_scale (
		.err    (err_in),
		.halves (ki_cur),
		.prod   (ki_prod)
	);

	bsl_gain_scale u_kp_scale (
		.err    (err_in),
		.halves (kp_cur),
		.prod   (kp_prod)
	);

	assign frozen_now = loop_freeze_until_carrier && !carrier_sense;
	assign upd        = err_valid && !frozen_now;

	// One extra shift turns half-step gains back into base units
	assign int_step = BSL_ACC_W'(ki_prod >>> (BSL_KI_SHIFT + 1));
	assign p_step   = BSL_ACC_W'(kp_prod >>> (BSL_KP_SHIFT + 1));

	always_comb begin
		case (clamp_code)
			BSL_CLAMP_OFF: lim = '0;
			BSL_CLAMP_LOW: lim = BSL_LIM_LOW;
			BSL_CLAMP_MID: lim = BSL_LIM_MID;
			default:       lim = BSL_LIM_HIGH;
		endcase
	end

	// Clamp runs every cycle so a tighter limit takes hold at once
	always_comb begin
		acc_sum = {acc_reg[BSL_ACC_W-1], acc_reg};
		if (upd) begin
			acc_sum = acc_sum + {int_step[BSL_ACC_W-1], int_step};
		end
		if (clamp_code == BSL_CLAMP_OFF) begin
			acc_next = '0;
		// Limits are widened as signed values so negative offsets compare
		end else if (acc_sum > $signed({lim[BSL_ACC_W-1], lim})) begin
			acc_next = lim;
		end else if (acc_sum < -$signed({lim[BSL_ACC_W-1], lim})) begin
			acc_next = -lim;
		end else begin
			acc_next = acc_sum[BSL_ACC_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= '0;
		end else begin
			acc_reg <= acc_next;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg_q   <= '0;
			adj_valid_reg <= 1'b0;
		end else begin
			adj_valid_reg <= upd;
			if (upd) begin
				phase_reg_q <= BSL_ACC_W'(p_step + acc_next);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ki_sel_reg <= '0;
			kp_sel_reg <= '0;
			frozen_reg <= 1'b0;
		end else begin
			ki_sel_reg <= ki_cur;
			kp_sel_reg <= kp_cur;
			frozen_reg <= frozen_now;
		end
	end

	assign reg_rd_data = rd_data_reg;
	assign adj_valid   = adj_valid_reg;
	assign phase_adj   = phase_reg_q;
	assign rate_offset = acc_reg;
	assign ki_sel      = ki_sel_reg;
	assign kp_sel      = kp_sel_reg;
	assign post_sync   = (phase_reg == BSL_POSTSYNC);
	assign loop_frozen = frozen_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_presync;
		// Sampled reset keeps the attempt at the release edge vacuous
		rst_n && !sync_detect && phase_reg == BSL_PRESYNC;
	endsequence

	sequence s_sync_held;
		sync_detect ##1 !rx_restart;
	endsequence

	property p_pre_ki;
		s_presync |=> ki_sel_reg ==
			{1'b0, $past(cfg_reg[7:6]), 1'b0} + 4'h2;
	endproperty
	a_pre_ki: assert property (p_pre_ki) else $error("pre ki wrong");

	property p_pre_kp;
		s_presync |=> kp_sel_reg ==
			{1'b0, $past(cfg_reg[5:4]), 1'b0} + 4'h2;
	endproperty
	a_pre_kp: assert property (p_pre_kp) else $error("pre kp wrong");

	property p_post_ki;
		sync_detect |=> ki_sel_reg == ($past(cfg_reg[3]) ? 4'h1 :
			{1'b0, $past(cfg_reg[7:6]), 1'b0} + 4'h2);
	endproperty
	a_post_ki: assert property (p_post_ki)
		else $error("post ki wrong");

	property p_post_kp;
		sync_detect |=> kp_sel_reg == ($past(cfg_reg[2]) ? 4'h2 :
			{1'b0, $past(cfg_reg[5:4]), 1'b0} + 4'h2);
	endproperty
	a_post_kp: assert property (p_post_kp)
		else $error("post kp wrong");

	property p_clamp;
		$past(clamp_code) == 2'h1 |-> rate_offset <= 16'sh0400
			&& rate_offset >= -16'sh0400;
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("offset past clamp");

	property p_off;
		clamp_code == 2'h0 |=> rate_offset == 16'sh0000;
	endproperty
	a_off: assert property (p_off)
		else $error("offset nonzero when off");

	property p_track;
		upd && err_in >= BSL_ERR_MIN_STEP && clamp_code != 2'h0
			&& acc_reg < 16'sh0000 && !reg_wr_en
			|=> rate_offset > $past(rate_offset);
	endproperty
	a_track: assert property (p_track)
		else $error("offset not tracking");

	property p_freeze;
		rst_n && loop_freeze_until_carrier && !carrier_sense && err_valid
			|=> !adj_valid && loop_frozen;
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("loop not frozen");

	property p_sync_hold;
		s_sync_held |-> post_sync;
	endproperty
	a_sync_hold: assert property (p_sync_hold)
		else $error("sync lost");

	property p_restart;
		rx_restart && !sync_detect |=> !post_sync;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart");
endmodule

// >>> bench/bsl_clk_loop_cfg_tb.sv
// Purpose: Self-checking bench for the clock recovery loop configuration
// Assumes: Model below is stepped on the same edges as the design
// Notes:   Every output is compared with the model on each falling edge with rst_n high, phase_adj only when adj_valid is expected
module bsl_clk_loop_cfg_tb
	import bsl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic                sys_clk, rst_n, reg_wr_en, loop_freeze_until_carrier;
	logic                carrier_sense, sync_detect, rx_restart, err_valid;
	logic         [5:0]  reg_addr;
	logic         [7:0]  reg_wr_data, reg_rd_data, m_cfg, m_rd;
	logic signed  [7:0]  err_in;
	logic                adj_valid, post_sync, loop_frozen;
	logic signed  [15:0] phase_adj, rate_offset;
	logic         [3:0]  ki_sel, kp_sel;
	logic         [31:0] seed = 32'h68E3;
	int                  bad_count, samples_checked;
	int                  m_rate, m_phase, m_ki, m_kp, m_adj, m_post, m_frz;

	bsl_clk_loop_cfg bsl_clk_loop_cfg_i (.sys_clk(sys_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
		.reg_rd_data(reg_rd_data),
		.loop_freeze_until_carrier(loop_freeze_until_carrier),
		.carrier_sense(carrier_sense), .sync_detect(sync_detect),
		.rx_restart(rx_restart), .err_valid(err_valid), .err_in(err_in),
		.adj_valid(adj_valid), .phase_adj(phase_adj),
		.rate_offset(rate_offset), .ki_sel(ki_sel), .kp_sel(kp_sel),
		.post_sync(post_sync), .loop_frozen(loop_frozen));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Reference loop, gains counted in halves of the base gain
	always @(posedge sys_clk or negedge rst_n) begin : model
		int e, ph, acc, r, lim;
		if (!rst_n) begin
			m_cfg = 8'h6C;
			{m_rd, m_rate, m_phase, m_ki, m_kp, m_adj, m_post, m_frz} = '0;
		end else begin
			e = err_in;
			// A restart only drops the post-sync gains from the next cycle
			ph = sync_detect | m_post;
			m_ki = 2 * (m_cfg[7:6] + 1);
			m_kp = 2 * (m_cfg[5:4] + 1);
			if (ph && m_cfg[3]) m_ki = 1;
			if (ph && m_cfg[2]) m_kp = 2;
			m_frz = loop_freeze_until_carrier & !carrier_sense;
			acc = err_valid & !m_frz;
			r = acc ? m_rate + ((e * m_ki) >>> 4) : m_rate;
			lim = (m_cfg[1:0] == 2'h0) ? 0 : 512 << m_cfg[1:0];
			if (r > lim) r = lim;
			if (r < -lim) r = -lim;
			if (acc) m_phase = ((e * m_kp) >>> 2) + r;
			m_rate = r;
			m_adj = acc;
			m_post = sync_detect | (m_post & !rx_restart);
			m_rd = (reg_addr == BSL_CFG_ADDR) ? m_cfg : 8'h00;
			if (reg_wr_en && reg_addr == BSL_CFG_ADDR) m_cfg = reg_wr_data;
		end
	end

	task automatic chk_val(input string nm, input logic [15:0] exp,
		input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	task automatic chk_reg(input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD reg_rd_data expected %0h seen %0h", exp, got);
		end
	endtask

	always @(negedge sys_clk) begin
		if (rst_n) begin
			chk_reg(m_rd, reg_rd_data);
			chk_val("ki_sel", m_ki[15:0], ki_sel);
			chk_val("kp_sel", m_kp[15:0], kp_sel);
			chk_val("post_sync", m_post[15:0], post_sync);
			chk_val("loop_frozen", m_frz[15:0], loop_frozen);
			chk_val("adj_valid", m_adj[15:0], adj_valid);
			chk_val("rate_offset", m_rate[15:0], rate_offset);
			if (m_adj != 0)
				chk_val("phase_adj", m_phase[15:0], phase_adj);
		end
	end

	// Fixed error of zero means a random error each cycle
	task automatic run(input int n, input logic signed [7:0] e);
		logic [31:0] r;
		repeat (n) begin
			@(posedge sys_clk);
			r = rnd();
			err_valid <= (e != 0) | r[0];
			err_in <= (e != 0) ? e : r[15:8];
			carrier_sense <= r[16];
			{reg_wr_en, sync_detect, rx_restart} <= 3'h0;
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wr_en <= 1'b1;
		reg_wr_data <= d;
		run(2, 8'sh00);
	endtask

	task automatic pulse(input logic s, input logic r);
		@(posedge sys_clk);
		sync_detect <= s;
		rx_restart <= r;
		run(3, 8'sh00);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// About 4800 cycles are expected; cut off well beyond that
	initial begin
		#400000;
		bad_count++;
		tally_and_finish();
	end

	initial begin
		logic [5:0] a;
		{rst_n, reg_wr_en, reg_wr_data, loop_freeze_until_carrier} = '0;
		{carrier_sense, sync_detect, rx_restart, err_valid, err_in} = '0;
		reg_addr = BSL_CFG_ADDR;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		run(6, 8'sh00);
		$display("reset values test done");
		for (int c = 0; c < 256; c++) begin
			wr(BSL_CFG_ADDR, c[7:0]);
			run(3, 8'sh00);
			pulse(1'b1, 1'b0);
			pulse(1'b0, 1'b1);
		end
		pulse(1'b1, 1'b1);
		$display("gain selection test done");
		for (int c = 0; c < 4; c++) begin
			wr(BSL_CFG_ADDR, {6'h30, c[1:0]});
			run(80, 8'sh7F);
			run(160, -8'sh80);
			run(40, 8'sh00);
		end
		$display("rate clamp test done");
		loop_freeze_until_carrier <= 1'b1;
		run(60, 8'sh00);
		loop_freeze_until_carrier <= 1'b0;
		run(4, 8'sh00);
		$display("freeze test done");
		repeat (4) begin
			a = rnd();
			if (a == BSL_CFG_ADDR) a = 6'h18;
			wr(a, rnd());
			reg_addr <= BSL_CFG_ADDR;
			run(2, 8'sh00);
		end
		$display("unmapped access test done");
		@(posedge sys_clk);
		rst_n <= 1'b0;
		@(posedge sys_clk);
		rst_n <= 1'b1;
		run(6, 8'sh00);
		$display("second reset test done");
		tally_and_finish();
	end
endmodule
